// ==== hw/hwrc_cfg.svh ====
// Constants for the halt, wake-up and reset sequencer
`ifndef HWRC_CFG_SVH
`define HWRC_CFG_SVH
`define HWRC_CLOCK_MHZ 50
`define HWRC_XST_CYCLES 1024
`define HWRC_CNT_W 11
`define HWRC_PC_RESET 11'h000
`define HWRC_SP_TOP 3'h0
`define HWRC_TMRC_RESET 5'h01
`define HWRC_RTC_CONTROL_RESET 6'h07
`define HWRC_INTERRUPT_CONTROL0_RESET 7'h00
`define HWRC_INTERRUPT_CONTROL1_RESET 4'h0
`define HWRC_PORTA_RESET 8'hff
`define HWRC_WDT_W 16
`endif

// ==== hw/hwrc_pkg.sv ====
// Types for the halt, wake-up and reset sequencer
package hwrc_pkg;
  typedef enum logic [1:0] {
    HWRC_RUN,
    HWRC_HALT,
    HWRC_WAIT
  } hwrc_state_type;

  // Wake reason latched at wake-up, used to pick the resume action
  typedef enum logic [1:0] {
    HWRC_WK_NONE,
    HWRC_WK_PORT,
    HWRC_WK_INT,
    HWRC_WK_WDT
  } hwrc_wake_type;

  // Peripheral register reset values handed to the rest of the chip
  typedef struct packed {
    logic [4:0] timer0_control;
    logic [4:0] timer1_control;
    logic [5:0] rtc_control;
    logic [6:0] interrupt_control0;
    logic [3:0] interrupt_control1;
    logic [7:0] port_a;
  } hwrc_regs_type;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } hwrc_flags_type;
endpackage

// ==== hw/hwrc_top.sv ====
// Halt mode, wake-up and reset sequencer
`timescale 1ns/1ns
`default_nettype none
`include "hwrc_cfg.svh"
module hwrc_top #(
  parameter bit CRYSTAL = 1'b1,
  parameter logic [7:0] PORTA_WAKE_EN = 8'hff,
  parameter bit WDT_OWN_CLOCK = 1'b1,
  parameter int XST_CYCLES = `HWRC_XST_CYCLES
) (
  input wire logic clock, // 50 MHz system clock
  input wire logic rst, // Power-up reset, synchronous, high
  input wire logic reset_pin_n, // External reset pin, low active
  input wire logic [7:0] port_a_pin, // Port A pins for wake-up
  input wire logic halt_instr, // Halt instruction executed
  input wire logic watchdog_clear_instr, // Watchdog clear instruction
  input wire logic watchdog_tick, // Watchdog clock enable pulse
  input wire logic [7:0] int_request, // Interrupt request flags
  input wire logic [7:0] int_enable, // Interrupt enables
  input wire logic global_int_enable, // Master interrupt enable
  input wire logic stack_full, // Call stack full
  input wire logic [3:0] wdt_period_sel, // Watchdog overflow bit select
  output logic sys_osc_enable, // System oscillator on
  output logic core_hold, // Core and state frozen
  output logic lcd_clock_enable, // LCD drive allowed
  output logic warm_reset, // One-cycle PC and SP clear
  output logic chip_reset, // Full chip reset level
  output logic resume_next, // Pulse: continue next instruction
  output logic int_vector, // Pulse: take interrupt vector
  output logic [10:0] pc_reset_value, // Program counter reset load
  output logic [2:0] sp_reset_value, // Stack pointer reset load
  output hwrc_pkg::hwrc_regs_type reg_reset_value, // Register reset loads
  output hwrc_pkg::hwrc_flags_type flags, // Timeout and powerdown flags
  output logic [15:0] watchdog_counter // Watchdog count
);
  localparam int XST_CNT = (XST_CYCLES < 1) ? 1 : XST_CYCLES;

  hwrc_pkg::hwrc_state_type state;
  hwrc_pkg::hwrc_state_type next_state;
  hwrc_pkg::hwrc_wake_type wake_kind;
  logic [1:0] rpin_sync;
  logic [7:0] pa_meta;
  logic [7:0] pa_sync;
  logic [7:0] pa_prev;
  logic [7:0] int_at_halt;
  logic [`HWRC_CNT_W-1:0] xst_count;
  logic rpin_prev;

  // Pins cross two flops; stage one feeds only stage two
  // Reset to the idle high level so no false edge follows reset
  always_ff @(posedge clock) begin
    if (rst) begin
      rpin_sync <= 2'h3;
      pa_meta <= 8'hff;
      pa_sync <= 8'hff;
      pa_prev <= 8'hff;
      rpin_prev <= 1'b1;
    end else begin
      rpin_sync <= {rpin_sync[0], reset_pin_n};
      pa_meta <= port_a_pin;
      pa_sync <= pa_meta;
      pa_prev <= pa_sync;
      rpin_prev <= rpin_sync[1];
    end
  end

  // Event decoding
  wire pin_reset = ~rpin_sync[1];
  wire pin_release = rpin_sync[1] & ~rpin_prev;
  wire in_halt = (state == hwrc_pkg::HWRC_HALT);
  wire in_run = (state == hwrc_pkg::HWRC_RUN);
  wire [7:0] pa_fall = pa_prev & ~pa_sync & PORTA_WAKE_EN;
  wire port_wake = |pa_fall;
  wire [7:0] int_new = int_request & ~int_at_halt;
  wire int_wake = |int_new;
  wire int_take = global_int_enable & |(int_new & int_enable) & ~stack_full;
  wire wdt_en = WDT_OWN_CLOCK | in_run; // Instruction clock stops in halt
  wire [15:0] wdt_mask = 16'h0001 << wdt_period_sel;
  wire wdt_over = watchdog_tick & wdt_en & ((watchdog_counter & wdt_mask) != 16'h0000);
  wire halt_go = in_run & halt_instr & ~pin_reset;
  wire wake_any = in_halt & (port_wake | int_wake | wdt_over);
  wire xst_done = (xst_count == `HWRC_CNT_W'(XST_CNT - 1));

  // Next state: crystal wake goes through the startup wait
  always_comb begin
    next_state = state;
    unique case (state)
      hwrc_pkg::HWRC_RUN: if (halt_go) next_state = hwrc_pkg::HWRC_HALT;
      hwrc_pkg::HWRC_HALT: begin
        if (pin_reset) begin
          next_state = hwrc_pkg::HWRC_RUN;
        end else if (wake_any) begin
          next_state = CRYSTAL ? hwrc_pkg::HWRC_WAIT : hwrc_pkg::HWRC_RUN;
        end
      end
      hwrc_pkg::HWRC_WAIT: begin
        if (pin_reset) begin
          next_state = hwrc_pkg::HWRC_RUN;
        end else if (xst_done) begin
          next_state = hwrc_pkg::HWRC_RUN;
        end
      end
    endcase
  end

  // Sequencer state, startup timer and wake reason
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= CRYSTAL ? hwrc_pkg::HWRC_WAIT : hwrc_pkg::HWRC_RUN;
      xst_count <= '0;
      wake_kind <= hwrc_pkg::HWRC_WK_NONE;
      int_at_halt <= 8'h00;
    end else begin
      state <= next_state;
      xst_count <= (state == hwrc_pkg::HWRC_WAIT) ? xst_count + 1'b1 : '0;
      if (halt_go) begin
        int_at_halt <= int_request;
      end
      if (wake_any) begin
        if (wdt_over) begin
          wake_kind <= hwrc_pkg::HWRC_WK_WDT;
        end else if (int_take) begin
          wake_kind <= hwrc_pkg::HWRC_WK_INT;
        end else begin
          wake_kind <= hwrc_pkg::HWRC_WK_PORT;
        end
      end
    end
  end

  // Resume actions fire when normal operation restarts
  wire resume_now = (next_state == hwrc_pkg::HWRC_RUN) & ~in_run & ~pin_reset & ~rst;
  wire [1:0] kind_now = wake_any ?
    (wdt_over ? 2'h3 : (int_take ? 2'h2 : 2'h1)) : 2'(wake_kind);
  logic int_delay;

  // Interrupt service is held one extra cycle after restart
  always_ff @(posedge clock) begin
    if (rst) begin
      resume_next <= 1'b0;
      int_delay <= 1'b0;
      int_vector <= 1'b0;
      warm_reset <= 1'b0;
    end else begin
      resume_next <= resume_now & ((kind_now == 2'h1) | (kind_now == 2'h2 & ~int_take
                     & (state == hwrc_pkg::HWRC_HALT)));
      int_delay <= resume_now & (kind_now == 2'h2);
      int_vector <= int_delay;
      warm_reset <= resume_now & (kind_now == 2'h3);
    end
  end

  // Full reset: power-up, pin, or watchdog overflow while running
  wire full_reset = rst | pin_reset | (in_run & wdt_over);
  always_ff @(posedge clock) begin
    if (rst) begin
      chip_reset <= 1'b1;
      pc_reset_value <= `HWRC_PC_RESET;
      sp_reset_value <= `HWRC_SP_TOP;
    end else begin
      chip_reset <= full_reset | (state == hwrc_pkg::HWRC_WAIT & ~wake_kind[0]
                    & ~wake_kind[1]);
      pc_reset_value <= `HWRC_PC_RESET;
      sp_reset_value <= `HWRC_SP_TOP;
    end
  end

  // Register reset values; a warm reset does not reload them
  always_ff @(posedge clock) begin
    if (full_reset) begin
      reg_reset_value.timer0_control <= `HWRC_TMRC_RESET;
      reg_reset_value.timer1_control <= `HWRC_TMRC_RESET;
      reg_reset_value.rtc_control <= `HWRC_RTC_CONTROL_RESET;
      reg_reset_value.interrupt_control0 <= `HWRC_INTERRUPT_CONTROL0_RESET;
      reg_reset_value.interrupt_control1 <= `HWRC_INTERRUPT_CONTROL1_RESET;
      reg_reset_value.port_a <= `HWRC_PORTA_RESET;
    end
  end

  // Status flags; halt has the strongest claim in its own cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      flags <= '0;
    end else if (pin_reset & in_halt) begin
      flags <= 2'b01;
    end else if (halt_go) begin
      flags <= 2'b01;
    end else if (wdt_over) begin
      flags.timeout_flag <= 1'b1;
      if (in_halt) begin
        flags.powerdown_flag <= 1'b1;
      end
    end else if (watchdog_clear_instr & in_run) begin
      flags.powerdown_flag <= 1'b0;
    end
  end

  // Watchdog count: cleared by reset, clear instruction, overflow, or halt when it has its own clock
  always_ff @(posedge clock) begin
    if (full_reset | (watchdog_clear_instr & in_run)) begin
      watchdog_counter <= 16'h0000;
    end else if (halt_go & WDT_OWN_CLOCK) begin
      watchdog_counter <= 16'h0000;
    end else if (wdt_over) begin
      watchdog_counter <= 16'h0000;
    end else if (watchdog_tick & wdt_en) begin
      watchdog_counter <= watchdog_counter + 16'h0001;
    end
  end

  // Clock gating; frozen core keeps RAM, registers and pins
  always_ff @(posedge clock) begin
    if (rst) begin
      sys_osc_enable <= 1'b1;
      core_hold <= 1'b1;
      lcd_clock_enable <= 1'b1;
    end else begin
      sys_osc_enable <= (next_state != hwrc_pkg::HWRC_HALT);
      core_hold <= (next_state != hwrc_pkg::HWRC_RUN);
      lcd_clock_enable <= (next_state != hwrc_pkg::HWRC_HALT) | WDT_OWN_CLOCK;
    end
  end

  // Startup wait lasts at least eight cycles once entered
  a_xst_length: assert property (@(posedge clock) disable iff (rst | pin_reset)
    $rose(state == hwrc_pkg::HWRC_WAIT) |-> (state == hwrc_pkg::HWRC_WAIT) [*8])
    else $error("startup wait ended early");

  // Startup wait ends as soon as the count is done
  a_xst_end: assert property (@(posedge clock) disable iff (rst)
    (state == hwrc_pkg::HWRC_WAIT) & xst_done & ~pin_reset |=> state == hwrc_pkg::HWRC_RUN)
    else $error("startup wait overran");

  // Halt sets powerdown and clears timeout
  a_halt_flags: assert property (@(posedge clock) disable iff (rst)
    halt_go & ~wdt_over |=> flags == 2'b01)
    else $error("halt did not set flags");

  // Oscillator gated once halt is entered
  a_osc_off: assert property (@(posedge clock) disable iff (rst)
    halt_go |=> ##1 !sys_osc_enable || state != hwrc_pkg::HWRC_HALT)
    else $error("oscillator not gated in halt");

  // Oscillator runs whenever the core runs
  a_osc_run: assert property (@(posedge clock) disable iff (rst)
    in_run |-> sys_osc_enable)
    else $error("oscillator off while running");

  // Core stays frozen for the whole halt
  a_halt_hold: assert property (@(posedge clock) disable iff (rst)
    in_halt |-> core_hold)
    else $error("core not frozen in halt");

  // Halt restarts the watchdog from zero when it has its own clock
  a_wdt_clear: assert property (@(posedge clock) disable iff (rst)
    halt_go & WDT_OWN_CLOCK & ~pin_reset |=> watchdog_counter == 16'h0000)
    else $error("halt left watchdog count");

  // LCD clock follows the watchdog clock source in halt
  a_lcd_halt: assert property (@(posedge clock) disable iff (rst)
    in_halt |-> (lcd_clock_enable == WDT_OWN_CLOCK))
    else $error("lcd clock wrong in halt");

  // A port fall leaves halt at once
  a_port_wake: assert property (@(posedge clock) disable iff (rst)
    in_halt & port_wake & ~pin_reset |=> state != hwrc_pkg::HWRC_HALT)
    else $error("port fall did not wake");

  // Watchdog clear instruction drops powerdown
  a_pd_clear: assert property (@(posedge clock) disable iff (rst)
    watchdog_clear_instr & in_run & ~wdt_over & ~halt_go & ~pin_reset
    |=> !flags.powerdown_flag)
    else $error("powerdown flag not cleared");

  // Full reset on the pin
  a_full_reset: assert property (@(posedge clock) disable iff (rst)
    pin_reset |=> chip_reset)
    else $error("pin reset without chip reset");

  // Pin reset in halt marks the cause
  a_flags_pin: assert property (@(posedge clock) disable iff (rst)
    pin_reset & in_halt |=> flags == 2'b01)
    else $error("pin wake flags wrong");

  // Watchdog in halt sets both flags and restarts the count
  a_flags_wdt: assert property (@(posedge clock) disable iff (rst)
    in_halt & wdt_over & ~pin_reset |=> flags == 2'b11)
    else $error("watchdog wake flags wrong");

  a_wdt_restart: assert property (@(posedge clock) disable iff (rst)
    in_halt & wdt_over |=> watchdog_counter == 16'h0000)
    else $error("watchdog count kept after wake");

  // Warm reset only with timeout, one cycle, registers untouched
  a_warm_wdt: assert property (@(posedge clock) disable iff (rst)
    warm_reset |-> flags.timeout_flag)
    else $error("warm reset without timeout flag");

  a_warm_pulse: assert property (@(posedge clock) disable iff (rst)
    warm_reset |=> !warm_reset)
    else $error("warm reset longer than a cycle");

  a_warm_keeps: assert property (@(posedge clock) disable iff (rst)
    warm_reset |-> $stable(reg_reset_value))
    else $error("warm reset reloaded registers");

  // Watchdog overflow while running is a full reset
  a_run_wdt: assert property (@(posedge clock) disable iff (rst)
    in_run & wdt_over & ~halt_go |=> chip_reset && flags.timeout_flag)
    else $error("running overflow not a full reset");

  // Full reset loads the register reset values
  a_regs_full: assert property (@(posedge clock) disable iff (rst)
    full_reset |=> reg_reset_value == {`HWRC_TMRC_RESET, `HWRC_TMRC_RESET,
    `HWRC_RTC_CONTROL_RESET, `HWRC_INTERRUPT_CONTROL0_RESET, `HWRC_INTERRUPT_CONTROL1_RESET, `HWRC_PORTA_RESET})
    else $error("register reset values wrong");

  // Next instruction runs only once the core is free
  a_resume_free: assert property (@(posedge clock) disable iff (rst)
    resume_next |-> !core_hold)
    else $error("resume while core frozen");

  // Vector comes one cycle after the core restarts
  a_int_late: assert property (@(posedge clock) disable iff (rst)
    int_vector |-> !core_hold && $past(core_hold, 2))
    else $error("interrupt vector not delayed");

  // A request pending at halt entry cannot wake
  a_pending_int: assert property (@(posedge clock) disable iff (rst)
    in_halt & ~port_wake & ~wdt_over & ~pin_reset & ((int_request & ~int_at_halt) == 8'h00)
    |=> state == hwrc_pkg::HWRC_HALT)
    else $error("stale interrupt woke halt");
endmodule
`default_nettype wire

// ==== tb/hwrc_pins_model.sv ====
// Model of the reset pin and the port A pins outside the sequencer
`timescale 1ns/1ns
`default_nettype none
module hwrc_pins_model (
  input wire logic clock, // System clock
  input wire logic fire_reset, // Request a reset pin pulse
  input wire logic fire_port, // Request a port A falling edge
  input wire logic [2:0] port_bit, // Port A bit to pull low
  output logic reset_pin_n, // Reset pin, low active
  output logic [7:0] port_a_pin // Port A pins, pulled high when idle
);
  int rst_cnt = 0;
  int port_cnt = 0;
  // Pin is held low eight cycles, well past the two-flop synchroniser
  always @(posedge clock) begin
    if (fire_reset) rst_cnt <= 8;
    else if (rst_cnt > 0) rst_cnt <= rst_cnt - 1;
    if (fire_port) port_cnt <= 4;
    else if (port_cnt > 0) port_cnt <= port_cnt - 1;
  end
  // Released port lines float back to the pull-up level
  assign reset_pin_n = (rst_cnt == 0);
  assign port_a_pin = (port_cnt == 0) ? 8'hff : ~(8'h01 << port_bit);
endmodule
`default_nettype wire

// ==== tb/hwrc_top_bench.sv ====
// Self-checking bench for the halt, wake-up and reset sequencer
`timescale 1ns/1ns
`default_nettype none
`include "hwrc_cfg.svh"
module hwrc_top_bench;
  localparam int CRYSTAL_STARTUP_TIMER = 16;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic halt_instr = 1'b0;
  logic watchdog_clear_instr = 1'b0;
  logic watchdog_tick = 1'b0;
  logic [7:0] int_request = 8'h00;
  logic [7:0] int_enable = 8'hff;
  logic global_int_enable = 1'b1;
  logic stack_full = 1'b0;
  logic [3:0] wdt_period_sel = 4'h0;
  logic fire_reset = 1'b0;
  logic fire_port = 1'b0;
  logic reset_pin_n;
  logic [7:0] port_a_pin;
  logic sys_osc_enable, core_hold, lcd_clock_enable, warm_reset, chip_reset;
  logic resume_next, int_vector;
  logic [10:0] pc_reset_value;
  logic [2:0] sp_reset_value;
  logic [15:0] watchdog_counter;
  hwrc_pkg::hwrc_regs_type reg_reset_value;
  hwrc_pkg::hwrc_flags_type flags;
  int n_mismatch = 0;
  int n_tests = 0;
  int n;

  // Free-running system clock, 20 ns period
  initial begin
    forever #10 clock = ~clock;
  end

  hwrc_pins_model pins_u (.clock(clock), .fire_reset(fire_reset), .fire_port(fire_port),
    .port_bit(3'h3), .reset_pin_n(reset_pin_n), .port_a_pin(port_a_pin));

  hwrc_top #(.XST_CYCLES(CRYSTAL_STARTUP_TIMER)) dut_u (.clock(clock), .rst(rst), .reset_pin_n(reset_pin_n),
    .port_a_pin(port_a_pin), .halt_instr(halt_instr),
    .watchdog_clear_instr(watchdog_clear_instr), .watchdog_tick(watchdog_tick),
    .int_request(int_request), .int_enable(int_enable),
    .global_int_enable(global_int_enable), .stack_full(stack_full),
    .wdt_period_sel(wdt_period_sel), .sys_osc_enable(sys_osc_enable),
    .core_hold(core_hold), .lcd_clock_enable(lcd_clock_enable), .warm_reset(warm_reset),
    .chip_reset(chip_reset), .resume_next(resume_next), .int_vector(int_vector),
    .pc_reset_value(pc_reset_value), .sp_reset_value(sp_reset_value),
    .reg_reset_value(reg_reset_value), .flags(flags), .watchdog_counter(watchdog_counter));

  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait on one outcome; a hang ends the run as a failure
  task automatic wait_for(input int sel, output int cyc);
    logic hit;
    cyc = 0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge clock);
      cyc++;
      case (sel)
        0: hit = (resume_next === 1'b1);
        1: hit = (warm_reset === 1'b1);
        2: hit = (int_vector === 1'b1);
        3: hit = (chip_reset === 1'b1);
        5: hit = (chip_reset === 1'b0);
        default: hit = (core_hold === 1'b0);
      endcase
      if (cyc > 300) begin
        n_mismatch++;
        conclude();
      end
    end
  endtask

  task automatic do_halt();
    @(negedge clock);
    halt_instr = 1'b1;
    @(negedge clock);
    halt_instr = 1'b0;
    @(negedge clock);
    check(sys_osc_enable, 1'b0);
    check(core_hold, 1'b1);
    check(flags, 2'b01);
    check(watchdog_counter, 16'h0000);
    check(lcd_clock_enable, 1'b1);
  endtask

  task automatic t_powerup();
    check(chip_reset, 1'b1);
    check(flags, 2'b00);
    check(reg_reset_value, {`HWRC_TMRC_RESET, `HWRC_TMRC_RESET, `HWRC_RTC_CONTROL_RESET,
      `HWRC_INTERRUPT_CONTROL0_RESET, `HWRC_INTERRUPT_CONTROL1_RESET, `HWRC_PORTA_RESET});
    check({pc_reset_value, sp_reset_value}, 14'h0000);
    wait_for(4, n);
    check(n >= CRYSTAL_STARTUP_TIMER - 2, 1'b1);
  endtask

  // Port wake resumes at the next instruction after the startup wait
  task automatic t_port_wake();
    do_halt();
    fire_port = 1'b1;
    @(negedge clock);
    fire_port = 1'b0;
    wait_for(0, n);
    check(n >= CRYSTAL_STARTUP_TIMER, 1'b1);
    check(int_vector, 1'b0);
  endtask

  // Stale request cannot wake; fresh one vectors, or resumes when stack is full
  task automatic t_int_wake(input logic full);
    stack_full = full;
    int_request = 8'h04;
    do_halt();
    repeat (40) @(negedge clock);
    check(core_hold, 1'b1);
    int_request = 8'h24;
    wait_for(full ? 0 : 2, n);
    check(n > CRYSTAL_STARTUP_TIMER, 1'b1);
    int_request = 8'h00;
    stack_full = 1'b0;
    @(negedge clock);
  endtask

  task automatic t_wdt_halt();
    do_halt();
    watchdog_tick = 1'b1;
    wait_for(1, n);
    watchdog_tick = 1'b0;
    check(chip_reset, 1'b0);
    wait_for(4, n);
    check(flags, 2'b11);
    watchdog_clear_instr = 1'b1;
    @(negedge clock);
    watchdog_clear_instr = 1'b0;
    @(negedge clock);
    check(flags.powerdown_flag, 1'b0);
  endtask

  task automatic t_pin_and_run();
    do_halt();
    fire_reset = 1'b1;
    @(negedge clock);
    fire_reset = 1'b0;
    wait_for(3, n);
    wait_for(4, n);
    check(flags, 2'b01);
    wait_for(5, n);
    watchdog_tick = 1'b1;
    wait_for(3, n);
    watchdog_tick = 1'b0;
    check(flags.timeout_flag, 1'b1);
    check(flags, 2'b11);
    wait_for(4, n);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_powerup();
    t_port_wake();
    t_int_wake(1'b0);
    t_int_wake(1'b1);
    t_wdt_halt();
    t_pin_and_run();
    conclude();
  end
endmodule
`default_nettype wire
